// file: rtl/splf_formatter.sv
// Serial link decoder and event word formatter for one link.
// Assumes link bits and APB signals are synchronous to sys_clk_in.
//
// What this block does
// - Strip hit block: leader, chip, channel, patterns
// - Leader-only block means an empty event
// - Strip error block: leader, chip, code, one
// - Hit pattern checked against compression setting
// - Strip packets packed two per 38-bit word
// - Link, time-out, condensed flags in sideband
// - Strip header and trailer packet layout
// - Condensed hit packet, one or two hits
// - Expanded first-hit and follow-on packets
// - Strip flagged-error and raw-data packets
// - All don't-care output bits are zero
// - Pixel packet: header, events, bunch, blocks
// - Pixel first block hit or chip error
// - Later pixel blocks may omit chip prefix
// - Pixel words 32 bits plus link, time-out
// - Pixel header word layout with bunch offset
// - Pixel hit word layout
// - Chip error word, old or new form
// - Time-out word and raw pixel words
// - Pixel trailer word with error flags
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module splf_formatter
  import splf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic link_bit_in,
  input wire logic link_bit_valid_in,
  input wire logic trigger_in,
  output logic [WORD_W-1:0] fmt_word_out,
  output logic fmt_valid_out
);
  typedef struct packed {
    splf_state_e st;
    logic [4:0] cnt;
    logic [31:0] sh;
    logic [3:0] chip;
    logic [6:0] chan;
    logic pend;
    logic pf;
    logic [6:0] pchan;
    logic [2:0] pdd;
    logic [15:0] pkts;
    logic hlim;
    logic ovf;
    logic zerr;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] tmo_cyc;
    logic [15:0] limit;
    logic [15:0] evcnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ev;
    logic [31:0] ed;
    logic e16;
    logic elast;
    logic etmo;
  } splf_main_s;
  splf_main_s q;
  splf_main_s n;

  logic hdr_seen;
  logic tmo_pulse;

  // Trigger arms the watchdog; a found header disarms it
  splf_timeout #(
    .CNT_W(16)
  ) u_timeout (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .arm_in(trigger_in && q.ctrl[CTL_EN]),
    .clear_in(hdr_seen),
    .cycles_in(q.tmo_cyc),
    .expire_out(tmo_pulse)
  );

  // Packer output flops drive the event word port
  splf_pack u_pack (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .pkt_valid_in(q.ev),
    .pkt_data_in(q.ed),
    .pkt_half_in(q.e16),
    .pkt_last_in(q.elast),
    .pkt_tmo_in(q.etmo),
    .pix_in(q.ctrl[CTL_PIX]),
    .cond_in(q.ctrl[CTL_COND]),
    .link_in(q.ctrl[CTL_LINK_HI:CTL_LINK_LO]),
    .word_out(fmt_word_out),
    .valid_out(fmt_valid_out)
  );

  // Whole next state: register port, link decoder, packet builder
  always_comb begin
    logic [31:0] nsh;
    logic [4:0] ncnt;
    logic pix;
    logic cond;
    logic qual;
    logic [2:0] dd;
    logic [6:0] hchan;
    logic dv;
    logic [31:0] dw;
    nsh = {q.sh[30:0], link_bit_in};
    ncnt = q.cnt + 5'h01;
    pix = q.ctrl[CTL_PIX];
    cond = q.ctrl[CTL_COND];
    dd = nsh[2:0];
    hchan = q.chan + 7'h01;
    dv = 1'b0;
    dw = 32'h0000_0000;
    qual = 1'b0;
    hdr_seen = 1'b0;
    n = q;
    n.ev = 1'b0;
    n.ed = 32'h0000_0000;
    n.e16 = 1'b1;
    n.elast = 1'b0;
    n.etmo = 1'b0;

    // Hit pattern qualifier per compression setting
    case (q.ctrl[CTL_CMP_HI:CTL_CMP_LO])
      CMP_ALIGN: qual = |dd;
      CMP_LEVEL: qual = dd[1];
      CMP_EDGE: qual = (dd[2:1] == 2'h1);
      default: qual = 1'b1;
    endcase

    // APB: decode in setup, answer in the first access cycle
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel_in && !penable_in) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr_in)
        ADDR_CTRL: n.prdata = 32'(q.ctrl);
        ADDR_TMO: n.prdata = 32'(q.tmo_cyc);
        ADDR_LIMIT: n.prdata = 32'(q.limit);
        ADDR_STAT: n.prdata = {q.evcnt, 10'h000, q.ovf, q.hlim, q.st};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (psel_in && penable_in && q.pready && pwrite_in && !q.pslverr) begin
      case (paddr_in)
        ADDR_CTRL: n.ctrl = pwdata_in[CTRL_W-1:0];
        ADDR_TMO: n.tmo_cyc = pwdata_in[15:0];
        ADDR_LIMIT: n.limit = pwdata_in[15:0];
        default: n.ctrl = q.ctrl;
      endcase
    end

    // Watchdog fired while waiting: stand-in event, flagged
    if (tmo_pulse && q.st == ST_HUNT) begin
      n.ev = 1'b1;
      n.e16 = 1'b0;
      n.etmo = 1'b1;
      n.elast = 1'b1;
      if (pix) begin
        n.ed = {PK_HDR, 29'h0000_0000};
      end else begin
        n.ed = {PK_HDR, 13'h0000, PK_TRL, 13'h0000};
      end
    end

    // Link decoder; one serial bit per valid strobe
    if (!q.ctrl[CTL_EN]) begin
      n.st = ST_HUNT;
      n.cnt = 5'h00;
    end else if (link_bit_valid_in) begin
      n.sh = nsh;
      n.cnt = ncnt;
      case (q.st)
        // Slide over idle bits until the header mark shows
        ST_HUNT: begin
          n.cnt = 5'h00;
          if (q.ctrl[CTL_RAW]) begin
            n.st = ST_RAW;
          end else if (nsh[4:0] == SYNC_HDR) begin
            hdr_seen = 1'b1;
            n.st = ST_HDR;
            n.pkts = 16'h0000;
            n.hlim = 1'b0;
            n.ovf = 1'b0;
            n.pend = 1'b0;
          end
        end
        // Event and bunch ids, then the sync bit
        ST_HDR: begin
          if (ncnt == (pix ? N_P_HDR : N_S_HDR)) begin
            n.st = ST_BLK;
            n.cnt = 5'h00;
            n.ev = 1'b1;
            n.evcnt = q.evcnt + 16'h0001;
            if (pix) begin
              n.e16 = 1'b0;
              n.ed = {PK_HDR, ~nsh[0], 8'h00,
                      q.ctrl[CTL_OFS_HI:CTL_OFS_LO],
                      nsh[12:9], nsh[8:5], 4'h0, nsh[4:1]};
            end else begin
              n.ed = {16'h0000, PK_HDR, ~nsh[0], nsh[12:9],
                      nsh[8:1]};
            end
          end
        end
        // Block start: sort by leader bits
        ST_BLK: begin
          if (pix) begin
            if (ncnt == N_P_BLK) begin
              if (nsh[3:0] == PIX_NEWFE) begin
                n.st = ST_PFE;
                n.cnt = 5'h00;
              end else begin
                n.st = ST_PSUB;
              end
            end
          end else if (q.cnt == 5'h00 && link_bit_in) begin
            n.st = ST_TRL;
            n.cnt = 5'h00;
            n.zerr = 1'b0;
          end else if (q.cnt == 5'h01 && link_bit_in) begin
            n.st = ST_HIT;
            n.cnt = 5'h00;
          end else if (q.cnt == 5'h02) begin
            n.st = link_bit_in ? ST_SYNC : ST_SERR;
            n.cnt = 5'h00;
          end
        end
        // Chip, channel, separator and first pattern
        ST_HIT: begin
          if (ncnt == N_S_HIT) begin
            n.chip = nsh[14:11];
            n.chan = nsh[10:4];
            n.st = ST_MORE;
            n.cnt = 5'h00;
            if (cond) begin
              n.pend = 1'b1;
              n.pchan = nsh[10:4];
              n.pf = ~qual;
            end else begin
              dv = 1'b1;
              dw = {16'h0000, 1'b1, nsh[14:11], nsh[10:4],
                    1'b0, dd};
            end
          end
        end
        // A one brings another pattern, a zero ends the block
        ST_MORE: begin
          n.cnt = 5'h00;
          if (link_bit_in) begin
            n.st = ST_DDD;
          end else begin
            n.st = ST_SYNC;
            n.pend = 1'b0;
            dv = q.pend;
            if (cond) begin
              dw = {16'h0000, 1'b1, q.chip, q.pchan, 1'b0,
                    q.pf, 2'h0};
            end else begin
              dw = {16'h0000, 1'b1, 7'h00, 1'b0, 3'h0,
                    1'b1, q.pdd};
            end
          end
        end
        // Further pattern, next channel up
        ST_DDD: begin
          if (ncnt == N_DDD) begin
            n.st = ST_MORE;
            n.cnt = 5'h00;
            n.chan = hchan;
            if (q.pend) begin
              n.pend = 1'b0;
              dv = 1'b1;
              if (cond) begin
                dw = {16'h0000, 1'b1, q.chip, q.pchan, ~qual,
                      q.pf, 2'h1};
              end else begin
                dw = {16'h0000, 1'b1, 7'h00, 1'b1, q.pdd,
                      1'b1, dd};
              end
            end else begin
              n.pend = 1'b1;
              n.pchan = hchan;
              n.pf = ~qual;
              n.pdd = dd;
            end
          end
        end
        // Chip error code and closing bit
        ST_SERR: begin
          if (ncnt == N_S_ERR) begin
            n.st = ST_SYNC;
            n.cnt = 5'h00;
            dv = 1'b1;
            dw = {16'h0000, 3'h0, 6'h00, nsh[7:4], nsh[3:1]};
          end
        end
        // Sync bit between blocks; a wrong value is tolerated
        ST_SYNC: begin
          n.st = ST_BLK;
          n.cnt = 5'h00;
        end
        // Trailer zeros; any one marks a trailer bit error
        ST_TRL: begin
          n.zerr = q.zerr | link_bit_in;
          if (ncnt == (pix ? N_P_TRL : N_S_TRL)) begin
            n.st = ST_HUNT;
            n.cnt = 5'h00;
            n.ev = 1'b1;
            n.elast = 1'b1;
            if (pix) begin
              n.e16 = 1'b0;
              n.ed = {PK_TRL, n.zerr, q.hlim, q.ovf,
                      26'h000_0000};
            end else begin
              n.ed = {16'h0000, PK_TRL, n.zerr, q.hlim, q.ovf,
                      10'h000};
            end
          end
        end
        // New chip number and its sync bit
        ST_PFE: begin
          if (ncnt == N_P_FE) begin
            n.chip = nsh[4:1];
            n.st = ST_PSUB;
            n.cnt = 5'h00;
          end
        end
        // Hit, chip error or trailer for the current chip
        ST_PSUB: begin
          if (ncnt == N_P_CHK && nsh[4:0] == PIX_FEERR) begin
            n.st = ST_PERR;
            n.cnt = 5'h00;
          end else if (ncnt == N_P_CHK && nsh[4:0] == PIX_TRL) begin
            n.st = ST_TRL;
            n.cnt = 5'h00;
            n.zerr = 1'b0;
          end else if (ncnt == N_P_HIT) begin
            n.st = ST_SYNC;
            n.cnt = 5'h00;
            dv = 1'b1;
            dw = {PK_HIT, 1'b0, q.chip, nsh[7:0], 3'h0,
                  nsh[12:8], nsh[20:13]};
          end
        end
        // Chip error code and controller error code
        ST_PERR: begin
          if (ncnt == N_P_ERR) begin
            n.st = ST_SYNC;
            n.cnt = 5'h00;
            dv = 1'b1;
            if (q.ctrl[CTL_NEWERR]) begin
              dw = {PK_ERR_NEW, q.chip, 5'h00, ERR_NEW_MARK,
                    3'h0, nsh[3:0], 3'h0, nsh[7:4]};
            end else begin
              dw = {PK_ERR_OLD, q.chip, 11'h000, ERR_OLD_MARK,
                    q.chip, nsh[7:4]};
            end
          end
        end
        // Raw capture bypasses parsing and the packet limit
        ST_RAW: begin
          if (!q.ctrl[CTL_RAW]) begin
            n.st = ST_HUNT;
            n.cnt = 5'h00;
          end else if (ncnt == (pix ? N_P_RAW : N_S_RAW)) begin
            n.cnt = 5'h00;
            n.ev = 1'b1;
            if (pix) begin
              n.e16 = 1'b0;
              n.ed = {PK_RAW, nsh[28:0]};
            end else begin
              n.ed = {16'h0000, PK_RAW, S_RAW_CNT, 2'h0, 2'h0,
                      nsh[5:0]};
            end
          end
        end
        default: begin
          n.st = ST_HUNT;
          n.cnt = 5'h00;
        end
      endcase
    end

    // Data packets count against the per-event limit
    if (dv) begin
      if (q.pkts >= q.limit) begin
        n.ovf = 1'b1;
        n.hlim = 1'b1;
      end else begin
        n.pkts = q.pkts + 16'h0001;
        n.hlim = (q.pkts + 16'h0001) >= q.limit;
        n.ev = 1'b1;
        n.e16 = ~pix;
        n.ed = dw;
      end
    end
  end

  // Single state register; software settings reset to defaults
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.tmo_cyc <= TMO_RST;
      q.limit <= LIMIT_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
endmodule : splf_formatter

// file: rtl/splf_pack.sv
// Packs strip packets two to a word and adds the sideband bits.
// Assumes at most one packet per cycle; 32-bit words pass whole.
`timescale 1ns/1ps
module splf_pack
  import splf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic pkt_valid_in,
  input wire logic [31:0] pkt_data_in,
  input wire logic pkt_half_in,
  input wire logic pkt_last_in,
  input wire logic pkt_tmo_in,
  input wire logic pix_in,
  input wire logic cond_in,
  input wire logic [3:0] link_in,
  output logic [WORD_W-1:0] word_out,
  output logic valid_out
);
  typedef struct packed {
    logic held;
    logic [15:0] half;
    logic [WORD_W-1:0] word;
    logic vld;
  } splf_pack_s;
  splf_pack_s q;
  splf_pack_s n;
  logic [5:0] side;

  // First packet of a pair lands in the upper half
  always_comb begin
    n = q;
    n.vld = 1'b0;
    side = {cond_in && !pix_in, pkt_tmo_in, link_in};
    if (pkt_valid_in) begin
      if (!pkt_half_in) begin
        n.word = {side, pkt_data_in};
        n.vld = 1'b1;
      end else if (q.held) begin
        n.word = {side, q.half, pkt_data_in[15:0]};
        n.held = 1'b0;
        n.vld = 1'b1;
      end else if (pkt_last_in) begin
        n.word = {side, pkt_data_in[15:0], 16'h0000};
        n.vld = 1'b1;
      end else begin
        n.held = 1'b1;
        n.half = pkt_data_in[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign word_out = q.word;
  assign valid_out = q.vld;
endmodule : splf_pack

// file: rtl/splf_pkg.sv
// Shared constants for the strip/pixel link formatter.
// Assumes one 20 MHz system clock and an APB register port.
package splf_pkg;
  // APB register map, byte addresses
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TMO = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // Control register fields
  localparam int CTRL_W = 15;
  localparam int CTL_EN = 0;
  localparam int CTL_PIX = 1;
  localparam int CTL_COND = 2;
  localparam int CTL_CMP_LO = 3;
  localparam int CTL_CMP_HI = 4;
  localparam int CTL_RAW = 5;
  localparam int CTL_NEWERR = 6;
  localparam int CTL_LINK_LO = 7;
  localparam int CTL_LINK_HI = 10;
  localparam int CTL_OFS_LO = 11;
  localparam int CTL_OFS_HI = 14;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
  localparam logic [15:0] TMO_RST = 16'h00c8;
  localparam logic [15:0] LIMIT_RST = 16'h0100;

  // Hit pattern compression settings
  localparam logic [1:0] CMP_ALIGN = 2'h0;
  localparam logic [1:0] CMP_LEVEL = 2'h1;
  localparam logic [1:0] CMP_EDGE = 2'h2;

  // Serial input marks
  localparam logic [4:0] SYNC_HDR = 5'h1d;
  localparam logic [3:0] PIX_NEWFE = 4'he;
  localparam logic [4:0] PIX_FEERR = 5'h1e;
  localparam logic [4:0] PIX_TRL = 5'h10;

  // Field lengths in serial bits
  localparam logic [4:0] N_S_HDR = 5'h0e;
  localparam logic [4:0] N_P_HDR = 5'h0d;
  localparam logic [4:0] N_S_HIT = 5'h0f;
  localparam logic [4:0] N_DDD = 5'h03;
  localparam logic [4:0] N_S_ERR = 5'h08;
  localparam logic [4:0] N_S_TRL = 5'h0f;
  localparam logic [4:0] N_P_TRL = 5'h12;
  localparam logic [4:0] N_P_BLK = 5'h04;
  localparam logic [4:0] N_P_FE = 5'h05;
  localparam logic [4:0] N_P_CHK = 5'h05;
  localparam logic [4:0] N_P_HIT = 5'h15;
  localparam logic [4:0] N_P_ERR = 5'h08;
  localparam logic [4:0] N_S_RAW = 5'h06;
  localparam logic [4:0] N_P_RAW = 5'h1d;
  localparam logic [2:0] S_RAW_CNT = 3'h7;

  // Output packet prefixes
  localparam logic [2:0] PK_HDR = 3'h1;
  localparam logic [2:0] PK_TRL = 3'h2;
  localparam logic [2:0] PK_RAW = 3'h3;
  localparam logic [2:0] PK_HIT = 3'h4;
  localparam logic [3:0] PK_ERR_OLD = 4'h0;
  localparam logic [3:0] PK_ERR_NEW = 4'h1;
  localparam logic [4:0] ERR_OLD_MARK = 5'h1e;
  localparam logic [4:0] ERR_NEW_MARK = 5'h1f;

  // Output word with sideband
  localparam int WORD_W = 38;

  typedef enum logic [3:0] {
    ST_HUNT, ST_HDR, ST_BLK, ST_HIT, ST_MORE, ST_DDD, ST_SERR,
    ST_SYNC, ST_TRL, ST_PFE, ST_PSUB, ST_PERR, ST_RAW
  } splf_state_e;
endpackage : splf_pkg

// file: rtl/splf_timeout.sv
// Header time-out watchdog for one link.
// Assumes trigger and header pulses are one cycle wide.
`timescale 1ns/1ps
module splf_timeout
  import splf_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic arm_in,
  input wire logic clear_in,
  input wire logic [CNT_W-1:0] cycles_in,
  output logic expire_out
);
  typedef struct packed {
    logic armed;
    logic [CNT_W-1:0] cnt;
    logic exp;
  } splf_tmo_s;
  splf_tmo_s q;
  splf_tmo_s n;

  // A header cancels the wait; zero cycles acts as one
  always_comb begin
    n = q;
    n.exp = 1'b0;
    if (clear_in) begin
      n.armed = 1'b0;
    end else if (arm_in && !q.armed) begin
      n.armed = 1'b1;
      n.cnt = cycles_in;
    end else if (q.armed) begin
      if (q.cnt <= CNT_W'(1)) begin
        n.armed = 1'b0;
        n.exp = 1'b1;
      end else begin
        n.cnt = q.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign expire_out = q.exp;
endmodule : splf_timeout

// file: verification/splf_chk.sv
// Port checker for the link formatter.
// Assumes one clock domain and a bind onto splf_formatter.
`timescale 1ns/1ps
module splf_chk
  import splf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [WORD_W-1:0] fmt_word_out,
  input wire logic fmt_valid_out
);
  logic [CTRL_W-1:0] ctrl_q;
  logic bad_addr;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Shadow control, taken where a write really lands
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= CTRL_RST;
    end else if (psel_in && penable_in && pready_out && pwrite_in
                 && paddr_in == ADDR_CTRL) begin
      ctrl_q <= pwdata_in[CTRL_W-1:0];
    end
  end
  // Unaligned or past the last register
  assign bad_addr = paddr_in[1:0] != 2'h0 || paddr_in > ADDR_STAT;
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_word;
    fmt_valid_out;
  endsequence
  property p_rdy_zero;
    s_setup |=> pready_out;
  endproperty
  property p_rdy_one;
    pready_out |=> !pready_out;
  endproperty
  property p_err_rdy;
    pslverr_out |-> pready_out;
  endproperty
  property p_unmapped;
    s_setup ##0 bad_addr |=> pslverr_out && prdata_out == 32'h0;
  endproperty
  property p_ctrl_read;
    s_setup ##0 (!pwrite_in && paddr_in == ADDR_CTRL)
      |=> !pslverr_out && prdata_out == 32'(ctrl_q);
  endproperty
  property p_wpulse;
    s_word |=> !fmt_valid_out;
  endproperty
  property p_hold;
    !fmt_valid_out |-> $stable(fmt_word_out);
  endproperty
  property p_side;
    s_word |-> fmt_word_out[35:32] == ctrl_q[CTL_LINK_HI:CTL_LINK_LO]
      && fmt_word_out[37] == (ctrl_q[CTL_COND] && !ctrl_q[CTL_PIX]);
  endproperty
  property p_tmo;
    s_word ##0 fmt_word_out[36] |-> fmt_word_out[31:0]
      == (ctrl_q[CTL_PIX] ? 32'h20000000 : 32'h20004000);
  endproperty
  property p_trl_zero;
    s_word ##0 (ctrl_q[CTL_PIX] && fmt_word_out[31:29] == PK_TRL)
      |-> fmt_word_out[25:0] == 26'h0;
  endproperty
  a_rdy_zero: assert property (p_rdy_zero) else $error("late pready");
  a_rdy_one: assert property (p_rdy_one) else $error("long pready");
  a_err_rdy: assert property (p_err_rdy) else $error("stray pslverr");
  a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
  a_wpulse: assert property (p_wpulse) else $error("long valid");
  a_hold: assert property (p_hold) else $error("word moved");
  a_side: assert property (p_side) else $error("sideband");
  a_tmo: assert property (p_tmo) else $error("time-out word");
  a_trl_zero: assert property (p_trl_zero) else $error("trl");
endmodule : splf_chk

bind splf_formatter splf_chk chk (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .fmt_word_out(fmt_word_out),
  .fmt_valid_out(fmt_valid_out)
);

// file: verification/splf_link_model.sv
// Serial source standing in for a front-end module.
// Assumes the bench queues whole blocks with push, msb first.
`timescale 1ns/1ps
module splf_link_model (
  input wire logic sys_clk_in,
  output logic link_bit_out,
  output logic link_valid_out
);
  bit bits_q[$];
  int gap = 0;
  int idle_cnt = 0;
  initial begin
    link_bit_out = 1'b0;
    link_valid_out = 1'b0;
  end
  task automatic push(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      bits_q.push_back(v[i]);
    end
  endtask : push
  // Gap gives slow senders; idle line toggles so nothing stale shows
  always @(posedge sys_clk_in) begin
    if (bits_q.size() > 0 && idle_cnt >= gap) begin
      link_bit_out <= bits_q.pop_front();
      link_valid_out <= 1'b1;
      idle_cnt <= 0;
    end else begin
      link_bit_out <= ~link_bit_out;
      link_valid_out <= 1'b0;
      idle_cnt <= idle_cnt + 1;
    end
  end
endmodule : splf_link_model

// file: verification/test_strip_pixel_link_formatter.sv
// Bench for the link formatter: APB set-up, strip and pixel events.
// Assumes the link model and checker files are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_strip_pixel_link_formatter
  import splf_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic rst_n_in, psel_in, penable_in, pwrite_in, trigger_in, pready_out;
  logic pslverr_out, lbit, lval, fmt_valid_out, er, cnd;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [WORD_W-1:0] fmt_word_out, e;
  logic [WORD_W-1:0] exp_q[$];
  logic [3:0] lk, l, f, m, b4;
  logic [7:0] b, t;
  logic [6:0] c, r;
  logic [2:0] ee, d;
  logic [4:0] cl;
  int fails = 0;
  int n_tests = 0;
  logic [7:0] ta[5] = '{ADDR_CTRL, ADDR_TMO, ADDR_LIMIT, ADDR_STAT, 8'h10};
  logic [31:0] tv[5] = '{32'h0, 32'hc8, 32'h100, 32'h0, 32'h0};
  localparam logic [31:0] CS = 32'h1 | (32'h1 << CTL_COND)
    | (32'(CMP_LEVEL) << CTL_CMP_LO) | (32'h5 << CTL_LINK_LO);
  localparam logic [31:0] CP = 32'h1 | (32'h1 << CTL_PIX)
    | (32'h1 << CTL_NEWERR) | (32'h9 << CTL_LINK_LO) | (32'h3 << CTL_OFS_LO);
  always #25 sys_clk_in = ~sys_clk_in;
  splf_formatter dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .link_bit_in(lbit), .link_bit_valid_in(lval), .trigger_in(trigger_in),
    .fmt_word_out(fmt_word_out), .fmt_valid_out(fmt_valid_out));
  splf_link_model lnk (.sys_clk_in(sys_clk_in), .link_bit_out(lbit),
    .link_valid_out(lval));
  task conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // One APB transfer; holds everything until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    if (pready_out !== 1'b1) fails++; // Bounded wait ran out
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task put(input logic [31:0] w);
    exp_q.push_back({cnd, 1'b0, lk, w});
  endtask : put
  // Let the model empty, then wait a bounded time for the words
  task run(input int g);
    int k;
    lnk.gap = g;
    for (k = 0; k < 4000 && (lnk.bits_q.size() > 0 || exp_q.size() > 0);
         k++) begin
      @(posedge sys_clk_in);
    end
    if (k >= 4000) fails++; // Bits or words stuck
  endtask : run
  // Every word is compared with the next expected word in exp_q, queued by put or pushed directly
  always @(posedge sys_clk_in) begin
    if (fmt_valid_out === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      `CHK("fmt word", e, fmt_word_out)
    end
  end
  // Hang guard, far beyond the expected run
  initial begin
    #(50 * 40000);
    fails++;
    conclude();
  end
  initial begin
    {psel_in, penable_in, pwrite_in, trigger_in, rst_n_in} = 5'h0;
    paddr_in = 8'h0;
    pwdata_in = 32'h0;
    rd = $urandom(6);
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ta[i], 32'h0);
      `CHK("reg read", tv[i], rd)
      `CHK("slave error", (i == 4), er)
    end
    apb(1'b1, ADDR_TMO, 32'h4);
    apb(1'b1, ADDR_CTRL, CS);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl read", CS, rd)
    lk = 4'h5;
    cnd = 1'b1;
    // Strip events: hit passing then failing the level check
    for (int i = 0; i < 2; i++) begin
      {l, b, f, c, ee, d} = 29'($urandom);
      d[1] = (i == 0);
      put({3'b001, 1'b0, l, b, 1'b1, f, c, 1'b0, ~d[1], 2'b00});
      put({3'b000, 6'h0, f, ee, 16'h4000});
      lnk.push({5'h1d, 1'b0, l, b, 1'b1}, 19);
      lnk.push({2'b01, f, c, 1'b1, d, 1'b0, 1'b1}, 19);
      lnk.push({3'b000, f, ee, 1'b1, 1'b1}, 12);
      lnk.push(64'h8000, 16);
      run(i * 2);
    end
    // Empty event, then a trigger with no header
    lnk.push({5'h1d, 1'b0, l, b, 1'b1}, 19);
    lnk.push(64'h3, 4);
    lnk.push(64'h8000, 16);
    put({3'b001, 1'b0, l, b, 16'h4000});
    run(0);
    exp_q.push_back({cnd, 1'b1, lk, 32'h20004000});
    trigger_in <= 1'b1;
    @(posedge sys_clk_in);
    trigger_in <= 1'b0;
    run(0);
    // Expanded strip event: first hit, a follow-on pair, a single
    apb(1'b1, ADDR_CTRL, CS & ~(32'h1 << CTL_COND));
    cnd = 1'b0;
    {l, b, f, c, ee, d} = 29'($urandom);
    put({3'b001, 1'b0, l, b, 1'b1, f, c, 1'b0, d});
    put({8'h80, 1'b1, ee, 1'b1, l[2:0], 8'h80, 5'h01, b[2:0]});
    put({16'h4000, 16'h0000});
    lnk.push({5'h1d, 1'b0, l, b, 1'b1}, 19);
    lnk.push({2'b01, f, c, 1'b1, d, 1'b1, ee, 1'b1, l[2:0], 1'b1, b[2:0],
              2'b01}, 31);
    lnk.push(64'h8000, 16);
    run(0);
    // Pixel event from a slow sender
    apb(1'b1, ADDR_CTRL, CP);
    lk = 4'h9;
    cnd = 1'b0;
    {m, l, b4, f, r, cl, t} = 36'({$urandom, $urandom});
    put({3'b001, 1'b0, 8'h0, 4'h3, m, l, 4'h0, b4});
    put({3'b100, 1'b0, f, t, 3'b0, cl, 1'b0, r});
    put({3'b100, 1'b0, f, ~t, 3'b0, ~cl, 1'b0, r});
    put({4'b0001, f, 5'h0, 5'h1f, 3'b0, m, 3'b0, l});
    put(32'h40000000);
    lnk.push({5'h1d, m, l, b4, 1'b1}, 18);
    lnk.push({4'he, f, 1'b1, 1'b0, r, cl, t, 1'b1}, 31);
    lnk.push({1'b0, r, ~cl, ~t, 1'b1}, 22);
    lnk.push({5'h1e, l, m, 1'b1}, 14);
    lnk.push(64'h400000, 23);
    run(2);
    // Pixel link left waiting after a trigger
    exp_q.push_back({cnd, 1'b1, lk, 32'h20000000});
    trigger_in <= 1'b1;
    @(posedge sys_clk_in);
    trigger_in <= 1'b0;
    run(0);
    `CHK("words left", 0, exp_q.size())
    conclude();
  end
endmodule : test_strip_pixel_link_formatter
